// ===== qdac_dev_model.sv
// Behavioural quad DAC: input and DAC registers fed by the host pins.
// Assumes pins come straight from the host; two_byte_i picks the variant.
`timescale 1ns/1ps

module qdac_dev_model
  import qdac_pkg::*;
#(
  parameter int CODE_W   = 12,
  parameter int GAIN_BIT = 15
) (
  input  wire qdac_pins_t  pins_i,      // Host pin levels
  input  wire logic        two_byte_i,  // Byte-load variant
  output logic [3:0][11:0] in_code_o,   // Input registers
  output logic [3:0][11:0] dac_code_o,  // DAC registers
  output logic [3:0]       dac_gain_o,  // Applied gain, 1 = twice range
  output logic             awake_o      // Outputs driven, else three-state
);
  logic [3:0] in_gain;
  logic [3:0] fresh;
  logic       wr_q;
  int         ch;

  initial begin
    in_code_o  = '0;
    dac_code_o = '0;
    dac_gain_o = '0;
    in_gain    = '0;
    fresh      = '0;
    wr_q       = 1'b1;
  end

  // Sleep gates the outputs only; registers are left alone
  assign awake_o = pins_i.pd_n;

  always @(pins_i.wr_n or pins_i.output_load_n_n or pins_i.clr_n) begin
    ch = int'(pins_i.addr);
    if (!pins_i.clr_n) begin
      in_code_o  = '0;
      dac_code_o = '0;
      dac_gain_o = '0;
      in_gain    = '0;
      fresh      = '0;
    end else begin
      if (pins_i.wr_n && !wr_q && !pins_i.cs_n) begin
        fresh[ch] = 1'b1;
        if (!two_byte_i) begin
          in_code_o[ch] = 12'(pins_i.data[CODE_W-1:0]);
          in_gain[ch]   = pins_i.data[GAIN_BIT];
        end else if (pins_i.upper_byte_select) begin
          in_code_o[ch][9:8] = pins_i.data[1:0];
        end else begin
          in_code_o[ch][7:0] = pins_i.data[7:0];
        end
      end
      // Transparent while low; only freshly written channels move
      if (!pins_i.output_load_n_n) begin
        for (int i = 0; i < 4; i++) begin
          if (fresh[i]) begin
            dac_code_o[i] = in_code_o[i];
            dac_gain_o[i] = in_gain[i];
          end
        end
        fresh = '0;
      end
    end
    wr_q = pins_i.wr_n;
  end
endmodule

// ===== qdac_host.sv
// Host controller for a quad parallel-load DAC: software port and pins.
// Assumes device pins are sampled by the DAC on wr_n rising edges; no
// read-back path exists on the device, so the bus is output only.
//
// Function
// - Synchronous mode keeps load pin low; update follows each write.
// - Asynchronous mode keeps load high during writes, pulses it later.
// - Two-byte mode: upper_byte_select 0 low byte, 1 high byte.
// - Gain may ride on any bus bit above the code bits.
`timescale 1ns/1ps
`include "qdac_regs.svh"

module qdac_host
  import qdac_pkg::*;
#(
  parameter int CODE_W   = 12,
  parameter int GAIN_BIT = `QDAC_DATA_GAIN
) (
  input  wire logic        clk_i,    // System clock, 25 MHz
  input  wire logic        rst_n_i,  // Async reset, active low
  input  wire logic [7:0]  addr_i,   // Register byte address
  input  wire logic [31:0] wdata_i,  // Write data
  input  wire logic        wr_i,     // Write strobe, one cycle
  input  wire logic        rd_i,     // Read strobe, one cycle
  output logic      [31:0] rdata_o,  // Read data, cycle after rd_i
  output qdac_pins_t       dev_o     // Device pin levels
);

  localparam int CH = `QDAC_CH_N;
  localparam int CW = `QDAC_CODE_MAX_W;
  localparam logic [CW:0] CODE_ONE = (CW+1)'(1);
  localparam logic [CW-1:0] CODE_MASK =
    CW'((CODE_ONE << CODE_W) - CODE_ONE);

  generate
    if (CODE_W != 8 && CODE_W != 10 && CODE_W != 12) begin : g_bad_code
      $error("qdac_host: CODE_W must be 8, 10 or 12");
    end
    if (GAIN_BIT < CODE_W || GAIN_BIT >= `QDAC_BUS_W) begin : g_bad_gain
      $error("qdac_host: GAIN_BIT must sit above code bits on the bus");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  qdac_ctrl_t          ctrl_ff,     nxt_ctrl;
  logic                load_req_ff, nxt_load_req;
  logic                wipe_req_ff, nxt_wipe_req;
  logic [CW-1:0]       code_ff     [CH];
  logic [CW-1:0]       nxt_code    [CH];
  logic [CH-1:0]       gain_ff,     nxt_gain;
  logic [CH-1:0]       pend_ff,     nxt_pend;
  logic [CH-1:0]       dirty_ff,    nxt_dirty;
  logic [31:0]         rdata_ff,    nxt_rdata;
  qdac_state_t         state_ff,    nxt_state;
  logic [1:0]          ch_ff,       nxt_ch;
  logic                half_ff,     nxt_half;
  qdac_pins_t          pins_ff,     nxt_pins;
  logic [CH-1:0]       served;
  logic [CH-1:0]       wrote;
  logic                load_go;
  logic                wipe_go;
  logic                step_start;
  logic [7:0]          step_len;
  logic                step_last;
  logic                wake_start;
  logic                wake_busy;
  logic                ctrl_hit;

  assign ctrl_hit = wr_i && (addr_i == `QDAC_CTRL_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_load_req = load_req_ff & ~load_go;
    nxt_wipe_req = wipe_req_ff & ~wipe_go;
    if (ctrl_hit) begin
      nxt_ctrl.sync      = wdata_i[`QDAC_CTRL_SYNC];
      nxt_ctrl.sleep     = wdata_i[`QDAC_CTRL_SLEEP];
      nxt_ctrl.byte_mode = wdata_i[`QDAC_CTRL_BYTE];
      // Load pulses only make sense in asynchronous mode
      if (wdata_i[`QDAC_CTRL_LOAD] && !wdata_i[`QDAC_CTRL_SYNC]) begin
        nxt_load_req = 1'b1;
      end
      if (wdata_i[`QDAC_CTRL_WIPE]) begin
        nxt_wipe_req = 1'b1;
      end
    end
  end

  // Shadow of each channel's code and gain; a new write wins over a clear
  for (genvar c = 0; c < CH; c++) begin : g_ch
    logic hit;
    assign hit = wr_i && (addr_i == 8'(`QDAC_DATA0_OFS + 4 * c));
    always_comb begin
      nxt_code[c]  = code_ff[c];
      nxt_gain[c]  = gain_ff[c];
      nxt_pend[c]  = pend_ff[c] & ~served[c];
      nxt_dirty[c] = dirty_ff[c] & ~load_go;
      if (wrote[c] && !ctrl_ff.sync) begin
        nxt_dirty[c] = 1'b1;
      end
      if (wipe_go) begin
        nxt_code[c]  = `QDAC_CODE_RST;
        nxt_gain[c]  = 1'b0;
        nxt_pend[c]  = 1'b0;
        nxt_dirty[c] = 1'b0;
      end
      if (hit) begin
        nxt_code[c] = wdata_i[CW-1:0] & CODE_MASK;
        nxt_gain[c] = wdata_i[`QDAC_DATA_GAIN];
        nxt_pend[c] = 1'b1;
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        code_ff[c]  <= `QDAC_CODE_RST;
        gain_ff[c]  <= 1'b0;
        pend_ff[c]  <= 1'b0;
        dirty_ff[c] <= 1'b0;
      end else begin
        code_ff[c]  <= nxt_code[c];
        gain_ff[c]  <= nxt_gain[c];
        pend_ff[c]  <= nxt_pend[c];
        dirty_ff[c] <= nxt_dirty[c];
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_i) begin
      if (addr_i == `QDAC_CTRL_OFS) begin
        nxt_rdata[`QDAC_CTRL_SYNC]  = ctrl_ff.sync;
        nxt_rdata[`QDAC_CTRL_SLEEP] = ctrl_ff.sleep;
        nxt_rdata[`QDAC_CTRL_BYTE]  = ctrl_ff.byte_mode;
      end else if (addr_i == `QDAC_STATUS_OFS) begin
        nxt_rdata[`QDAC_STAT_BUSY] = (state_ff != QDAC_ST_IDLE) ||
                                     (|pend_ff) || load_req_ff || wipe_req_ff;
        nxt_rdata[`QDAC_STAT_WAKE] = wake_busy;
        nxt_rdata[`QDAC_STAT_DIRTY +: CH] = dirty_ff;
        nxt_rdata[`QDAC_STAT_PEND +: CH]  = pend_ff;
      end else begin
        for (int c = 0; c < CH; c++) begin
          if (addr_i == 8'(`QDAC_DATA0_OFS + 4 * c)) begin
            nxt_rdata[CW-1:0]             = code_ff[c];
            nxt_rdata[`QDAC_DATA_GAIN]    = gain_ff[c];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff     <= `QDAC_CTRL_RST;
      load_req_ff <= 1'b0;
      wipe_req_ff <= 1'b0;
      rdata_ff    <= 32'h0000_0000;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      load_req_ff <= nxt_load_req;
      wipe_req_ff <= nxt_wipe_req;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sequencer
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_state  = state_ff;
    nxt_ch     = ch_ff;
    nxt_half   = half_ff;
    nxt_pins   = pins_ff;
    served     = '0;
    wrote      = '0;
    load_go    = 1'b0;
    wipe_go    = 1'b0;
    step_start = 1'b0;
    step_len   = 8'(`QDAC_WR_LOW_CYC);
    case (state_ff)
      QDAC_ST_IDLE: begin
        // Loads only start from idle, so both bytes are already in
        if (wipe_req_ff) begin
          nxt_state  = QDAC_ST_WIPE;
          step_start = 1'b1;
          step_len   = 8'(`QDAC_WIPE_CYC);
          wipe_go    = 1'b1;
        end else if (load_req_ff) begin
          nxt_state  = QDAC_ST_LOAD;
          step_start = 1'b1;
          step_len   = 8'(`QDAC_LOAD_CYC);
          load_go    = 1'b1;
        end else if (|pend_ff) begin
          for (int c = CH - 1; c >= 0; c--) begin
            if (pend_ff[c]) begin
              nxt_ch = 2'(c);
            end
          end
          served[nxt_ch] = 1'b1;
          nxt_half       = 1'b0;
          nxt_state      = QDAC_ST_SETUP;
        end
      end
      QDAC_ST_SETUP: begin
        nxt_state  = QDAC_ST_STROBE;
        step_start = 1'b1;
      end
      QDAC_ST_STROBE: begin
        if (step_last) begin
          nxt_state = QDAC_ST_HOLD;
        end
      end
      QDAC_ST_HOLD: begin
        if (ctrl_ff.byte_mode && !half_ff) begin
          nxt_half  = 1'b1;
          nxt_state = QDAC_ST_SETUP;
        end else begin
          wrote[ch_ff] = 1'b1;
          nxt_state    = QDAC_ST_IDLE;
        end
      end
      QDAC_ST_LOAD, QDAC_ST_WIPE: begin
        if (step_last) begin
          nxt_state = QDAC_ST_IDLE;
        end
      end
      default: begin
        nxt_state = QDAC_ST_IDLE;
      end
    endcase

    // Address and data change only on entry to setup
    if (nxt_state == QDAC_ST_SETUP) begin
      nxt_pins.addr = nxt_ch;
      nxt_pins.data = '0;
      if (ctrl_ff.byte_mode) begin
        nxt_pins.upper_byte_select = nxt_half;
        if (nxt_half) begin
          nxt_pins.data[1:0] = code_ff[nxt_ch][9:8];
        end else begin
          nxt_pins.data[7:0] = code_ff[nxt_ch][7:0];
        end
      end else begin
        nxt_pins.upper_byte_select           = 1'b0;
        nxt_pins.data[CW-1:0]   = code_ff[nxt_ch];
        nxt_pins.data[GAIN_BIT] = gain_ff[nxt_ch];
      end
    end
    nxt_pins.cs_n   = !(nxt_state == QDAC_ST_SETUP ||
                        nxt_state == QDAC_ST_STROBE ||
                        nxt_state == QDAC_ST_HOLD);
    nxt_pins.wr_n   = (nxt_state != QDAC_ST_STROBE);
    nxt_pins.output_load_n_n = !(ctrl_ff.sync ||
                        nxt_state == QDAC_ST_LOAD);
    nxt_pins.clr_n  = (nxt_state != QDAC_ST_WIPE);
    nxt_pins.pd_n   = !nxt_ctrl.sleep;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff     <= QDAC_ST_IDLE;
      ch_ff        <= 2'h0;
      half_ff      <= 1'b0;
      pins_ff      <= '0;
      pins_ff.cs_n <= 1'b1;
      pins_ff.wr_n <= 1'b1;
      pins_ff.output_load_n_n <= 1'b1;
      pins_ff.clr_n  <= 1'b1;
      pins_ff.pd_n   <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      ch_ff    <= nxt_ch;
      half_ff  <= nxt_half;
      pins_ff  <= nxt_pins;
    end
  end

  assign dev_o = pins_ff;

  qdac_timer #(.W(8)) u_step (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (step_start),
    .len_i   (step_len),
    .busy_o  (),
    .last_o  (step_last)
  );

  // Wake time runs from the sleep pin rising
  assign wake_start = ctrl_ff.sleep && !nxt_ctrl.sleep;

  qdac_timer #(.W(8)) u_wake (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (wake_start),
    .len_i   (8'(`QDAC_WAKE_CYC)),
    .busy_o  (wake_busy),
    .last_o  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wr_needs_cs_a: assert property (!dev_o.wr_n |-> !dev_o.cs_n)
    else $error("Write strobe low without chip select");

  strobe_width_a: assert property (
    $fell(dev_o.wr_n) |-> (!dev_o.wr_n)[*2] ##1 dev_o.wr_n)
    else $error("Write strobe low time wrong");

  bus_stable_a: assert property (
    !dev_o.wr_n |=> $stable(dev_o.addr) && $stable(dev_o.upper_byte_select) &&
                   $stable(dev_o.data))
    else $error("Address or data moved at strobe rise");

  high_byte_a: assert property (
    $rose(dev_o.wr_n) && dev_o.upper_byte_select |-> dev_o.data[7:2] == 6'h00)
    else $error("High byte drives unused bits");

  async_hold_a: assert property (
    !ctrl_ff.sync && $past(ctrl_ff.sync) == 1'b0 && !dev_o.wr_n
    |-> dev_o.output_load_n_n)
    else $error("Load low during asynchronous write");

  sync_low_a: assert property (
    ctrl_ff.sync && $past(ctrl_ff.sync) |-> !dev_o.output_load_n_n)
    else $error("Load pin high in synchronous mode");

  load_clears_a: assert property (
    state_ff == QDAC_ST_LOAD |-> dirty_ff == 4'h0 && !dev_o.output_load_n_n)
    else $error("Dirty channels left after load");

  wipe_clears_a: assert property (
    !dev_o.clr_n |-> dirty_ff == 4'h0 && dev_o.cs_n)
    else $error("Wipe overlaps a write or leaves dirty state");

  sleep_pin_a: assert property (
    ctrl_ff.sleep |-> !dev_o.pd_n ##1 (ctrl_ff.sleep || dev_o.pd_n))
    else $error("Sleep pin does not follow control");

  wake_wait_a: assert property (
    $rose(dev_o.pd_n) |-> wake_busy[*8])
    else $error("Wake time not tracked");

endmodule

// ===== qdac_host_tb.sv
// Self-checking bench for the quad DAC host controller.
// Assumes qdac_host and the behavioural DAC model are compiled first.
`timescale 1ns/1ps

module qdac_host_tb
  import qdac_pkg::*;
  ;
  logic             clk_i   = 1'b0;
  logic             rst_n_i = 1'b0;
  logic [7:0]       addr_i  = '0;
  logic [31:0]      wdata_i = '0;
  logic             wr_i    = 1'b0;
  logic             rd_i    = 1'b0;
  logic [31:0]      rdata_o;
  qdac_pins_t       dev_o;
  logic             byte_v  = 1'b0;
  logic [3:0][11:0] in_code;
  logic [3:0][11:0] dac_code;
  logic [3:0]       dac_gain;
  logic             awake;
  logic [31:0]      rv;
  int               fail_count  = 0;
  int               checks_done = 0;

  always #20 clk_i = ~clk_i;

  qdac_host u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dev_o(dev_o)
  );

  qdac_dev_model u_dac (
    .pins_i(dev_o), .two_byte_i(byte_v), .in_code_o(in_code),
    .dac_code_o(dac_code), .dac_gain_o(dac_gain), .awake_o(awake)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Poll busy with a bound
  task automatic wait_idle();
    int n;
    n  = 0;
    rv = 32'h1;
    while (rv[0] !== 1'b0 && n < 300) begin
      rd(8'h04, rv);
      n++;
    end
    chk("busy", 64'h0, rv[0]);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Strobe low with chip deselected would be a stray write
  always @(posedge clk_i) begin
    if (rst_n_i && dev_o.wr_n === 1'b0 && dev_o.cs_n !== 1'b0) begin
      fail_count++;
      $display("unexpected strobe: expected cs_n 0 seen %b", dev_o.cs_n);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("unexpected timeout: expected end seen none");
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("pins", 5'h1F, {dev_o.cs_n, dev_o.wr_n, dev_o.output_load_n_n,
        dev_o.clr_n, dev_o.pd_n});
    chk("rdata", 64'h0, rdata_o);
    rd(8'h00, rv);
    chk("ctrl", 64'h0, rv);
    chk("dac", 64'h0, dac_code);
    $display("test reset done");

    for (int i = 0; i < 4; i++)
      wr(8'h10 + 8'(4 * i), {16'h0, 1'(i), 3'h0, 12'hA50 + 12'(i)});
    wait_idle();
    chk("input", 48'hA53A_52A5_1A50, in_code);
    chk("held", 64'h0, dac_code);
    chk("dirty", 4'hF, rv[7:4]);
    wr(8'h00, 32'h0000_0008);
    wait_idle();
    chk("loaded", 48'hA53A_52A5_1A50, dac_code);
    chk("gain", 4'hA, dac_gain);
    chk("dirty", 4'h0, rv[7:4]);
    $display("test async done");

    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, rv);
    chk("unmapped", 64'h0, rv);
    rd(8'h00, rv);
    chk("ctrl", 64'h0, rv);
    $display("test unmapped done");

    wr(8'h00, 32'h0000_0009);
    rd(8'h04, rv);
    chk("refused load", 64'h0, rv[0]);
    chk("load pin", 64'h0, dev_o.output_load_n_n);
    wr(8'h18, 32'h0000_03C3);
    wait_idle();
    chk("sync", 12'h3C3, dac_code[2]);
    $display("test sync done");

    wr(8'h00, 32'h0000_0011);
    wait_idle();
    chk("wipe", 64'h0, {in_code, dac_gain});
    chk("wipe dac", 64'h0, dac_code);
    $display("test wipe done");

    byte_v <= 1'b1;
    wr(8'h00, 32'h0000_0005);
    rd(8'h00, rv);
    chk("ctrl", 64'h5, rv);
    wr(8'h1C, 32'h0000_0EA5);
    wait_idle();
    chk("byte", 12'h2A5, dac_code[3]);
    $display("test byte done");

    byte_v <= 1'b0;
    wr(8'h00, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("sleep pin", 64'h0, {dev_o.pd_n, awake});
    wr(8'h10, 32'h0000_0155);
    wait_idle();
    wr(8'h00, 32'h0000_000A);
    wait_idle();
    chk("asleep", 24'h2A_5155, {dac_code[3], dac_code[0]});
    wr(8'h00, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    rd(8'h04, rv);
    chk("waking", 64'h1, rv[1]);
    repeat (130) @(posedge clk_i);
    rd(8'h04, rv);
    chk("awake", 64'h0, rv[1]);
    $display("test sleep done");
    results();
  end
endmodule

// ===== qdac_pkg.sv
// Types shared by the quad DAC host controller.
// Assumes qdac_regs.svh is on the include path.
`include "qdac_regs.svh"

package qdac_pkg;

  // Levels driven onto the device pins
  typedef struct packed {
    logic                   cs_n;
    logic                   wr_n;
    logic                   output_load_n_n;
    logic                   clr_n;
    logic                   pd_n;
    logic [1:0]             addr;
    logic                   upper_byte_select;
    logic [`QDAC_BUS_W-1:0] data;
  } qdac_pins_t;

  // Software controls held in CTRL
  typedef struct packed {
    logic byte_mode;
    logic sleep;
    logic sync;
  } qdac_ctrl_t;

  typedef enum logic [5:0] {
    QDAC_ST_IDLE   = 6'b00_0001,
    QDAC_ST_SETUP  = 6'b00_0010,
    QDAC_ST_STROBE = 6'b00_0100,
    QDAC_ST_HOLD   = 6'b00_1000,
    QDAC_ST_LOAD   = 6'b01_0000,
    QDAC_ST_WIPE   = 6'b10_0000
  } qdac_state_t;

endpackage

// ===== qdac_regs.svh
// Constants of the quad DAC host controller: register map, fields, timing.
// Assumes inclusion by bare name from the package and the host module.
`ifndef QDAC_REGS_SVH
`define QDAC_REGS_SVH

// Device pin bus
`define QDAC_BUS_W        16
`define QDAC_CODE_MAX_W   12
`define QDAC_CH_N         4

// Register offsets on the software port
`define QDAC_CTRL_OFS     8'h00
`define QDAC_STATUS_OFS   8'h04
`define QDAC_DATA0_OFS    8'h10

// CTRL fields
`define QDAC_CTRL_SYNC    0
`define QDAC_CTRL_SLEEP   1
`define QDAC_CTRL_BYTE    2
`define QDAC_CTRL_LOAD    3
`define QDAC_CTRL_WIPE    4

// DATA fields
`define QDAC_DATA_GAIN    15

// STATUS fields
`define QDAC_STAT_BUSY    0
`define QDAC_STAT_WAKE    1
`define QDAC_STAT_DIRTY   4
`define QDAC_STAT_PEND    8

// Reset values
`define QDAC_CTRL_RST     3'h0
`define QDAC_CODE_RST     12'h000

// Timing
`define QDAC_CLK_MHZ      25
`define QDAC_WR_LOW_CYC   2
`define QDAC_LOAD_CYC     2
`define QDAC_WIPE_CYC     2
`define QDAC_WAKE_NS      5000
`define QDAC_WAKE_CYC     ((`QDAC_WAKE_NS * `QDAC_CLK_MHZ + 999) / 1000)

`endif

// ===== qdac_timer.sv
// Down-counter that times one phase of the pin sequence.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps

module qdac_timer #(
  parameter int W = 8
) (
  input  wire logic         clk_i,    // System clock
  input  wire logic         rst_n_i,  // Async reset, active low
  input  wire logic         start_i,  // Load the count
  input  wire logic [W-1:0] len_i,    // Cycles to run
  output logic              busy_o,   // Count not yet zero
  output logic              last_o    // Final cycle or idle
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  generate
    if (W < 2) begin : g_bad_width
      $error("qdac_timer: W must be at least 2");
    end
  endgenerate

  always_comb begin
    nxt_cnt = cnt_ff;
    if (start_i) begin
      nxt_cnt = len_i;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (cnt_ff != '0);
  assign last_o = (cnt_ff <= W'(1));

endmodule
